/* include/shrp_cfg.svh */
// Constants of the serial host register port: field widths, counts and bit positions.
// Assumes nothing of its surroundings; included by bare name wherever a number is needed.
`ifndef SHRP_CFG_SVH
`define SHRP_CFG_SVH

// Instruction, address and data phase widths, in serial clock edges.
`define SHRP_INSTR_W 5
`define SHRP_ADDR_W 11
`define SHRP_DATA_W 8

// Width of the per-phase bit counter; it must hold the longest phase length minus one.
`define SHRP_CNT_W 4

// Shift register holds the address followed by the data byte.
`define SHRP_SHIFT_W (`SHRP_ADDR_W + `SHRP_DATA_W)

// Position of the instruction MSB inside the shift register just before the last instruction edge.
`define SHRP_OP_BIT (`SHRP_INSTR_W - 2)

// Instruction MSB value that selects a register read.
`define SHRP_OP_READ_VAL 1'b1

// Number of implemented registers; addresses at or above it read as zero and ignore writes.
`define SHRP_NUM_REGS 32

// Reset value of every implemented register.
`define SHRP_REG_RESET 8'h00

`endif

/* include/shrp_pkg.sv */
// Types shared by the serial host register port modules.
// Assumes shrp_cfg.svh is on the include path.
package shrp_pkg;

  // Phase of a serial transfer, advanced on the rising serial clock edge.
  typedef enum logic [1:0] {
    SHRP_PH_INSTR,
    SHRP_PH_ADDR,
    SHRP_PH_DATA,
    SHRP_PH_DONE
  } shrp_phase_e;

  // Operation decoded from the instruction MSB.
  typedef enum logic {
    SHRP_OP_WRITE,
    SHRP_OP_READ
  } shrp_op_e;

endpackage

/* hdl/shrp_sync.sv */
// Two flip-flop level synchroniser, one chain per bit.
// Assumes each input bit is a level that stays put for at least two destination clock periods.
`timescale 1ns/1ps
`default_nettype none

module shrp_sync
  import shrp_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  // Clock and reset of the destination domain.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Levels from the other domain and their synchronised copies.
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  // The first stage feeds only the second stage, never any other logic.
  for (genvar b = 0; b < WIDTH; b++)
  begin : g_bit
    always_comb
    begin
      next_meta[b] = async_i[b];
      next_sync[b] = meta[b];
    end
  end

  // Both stages clear synchronously so the chain starts from a known low level.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta   <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta   <= next_meta;
      sync_o <= next_sync;
    end
  end

endmodule

`default_nettype wire

/* hdl/shrp_regfile.sv */
// Register storage reached through the serial port, held in flip-flops on the system clock.
// Assumes write and read strobes are single-cycle pulses whose address and data are stable.
`timescale 1ns/1ps
`default_nettype none
`include "shrp_cfg.svh"

module shrp_regfile
  import shrp_pkg::*;
#(
  parameter int NUM_REGS = `SHRP_NUM_REGS,
  parameter int ADDR_W   = `SHRP_ADDR_W,
  parameter int DATA_W   = `SHRP_DATA_W
)
(
  // System clock and synchronous reset.
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Write port.
  input  wire logic                       we_i,
  input  wire logic [ADDR_W-1:0]          waddr_i,
  input  wire logic [DATA_W-1:0]          wdata_i,
  // Read port; data appears one cycle after the strobe and then holds.
  input  wire logic                       re_i,
  input  wire logic [ADDR_W-1:0]          raddr_i,
  output logic      [DATA_W-1:0]          rdata_o,
  // Every register's contents, for the logic that the registers steer.
  output logic      [NUM_REGS*DATA_W-1:0] regs_o
);

  logic [NUM_REGS*DATA_W-1:0] next_regs;
  logic [DATA_W-1:0]          next_rdata;

  // Each entry loads only when the write address selects it.
  for (genvar i = 0; i < NUM_REGS; i++)
  begin : g_entry
    always_comb
    begin
      next_regs[i*DATA_W +: DATA_W] = regs_o[i*DATA_W +: DATA_W];
      if (we_i && (waddr_i == ADDR_W'(i)))
        next_regs[i*DATA_W +: DATA_W] = wdata_i;
    end
  end

  // Read data holds between reads so the serial side can sample it at leisure.
  always_comb
  begin
    next_rdata = rdata_o;
    if (re_i)
    begin
      if (raddr_i < ADDR_W'(NUM_REGS))
        next_rdata = regs_o[raddr_i*DATA_W +: DATA_W];
      else
        next_rdata = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      regs_o  <= {NUM_REGS{`SHRP_REG_RESET}};
      rdata_o <= '0;
    end
    else
    begin
      regs_o  <= next_regs;
      rdata_o <= next_rdata;
    end
  end

endmodule

`default_nettype wire

/* hdl/shrp_top.sv */
// Serial host register port: a host reads and writes internal registers over a four-wire link.
// Assumes the host drives chip select, serial clock and serial data in, and resolves the
// serial data out pin from the output enable; the serial clock may stop while chip select is high.
//
// Functional notes
// - Chip select low frames one transfer.
// - Five instruction bits sampled on rising clock.
// - Instruction MSB one means register read.
// - Instruction MSB zero means register write.
// - Eleven address bits follow, selecting the register.
// - Read data driven out on falling edges.
// - Write data follows address, stored in register.
`timescale 1ns/1ps
`default_nettype none
`include "shrp_cfg.svh"

module shrp_top
  import shrp_pkg::*;
#(
  parameter int NUM_REGS = `SHRP_NUM_REGS,
  parameter int ADDR_W   = `SHRP_ADDR_W,
  parameter int DATA_W   = `SHRP_DATA_W
)
(
  // System clock domain.
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_i,
  // Serial link, clocked by the host.
  input  wire logic                       serial_clock_i,
  input  wire logic                       chip_select_n_i,
  input  wire logic                       serial_data_in_i,
  output logic                            serial_data_out_o,
  output logic                            serial_data_out_oe_o,
  // Register contents and access strobes for the rest of the device.
  output logic      [NUM_REGS*DATA_W-1:0] reg_values_o,
  output logic                            write_strobe_o,
  output logic                            read_strobe_o,
  output logic      [ADDR_W-1:0]          access_addr_o
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Link domain, rising edge: instruction, address and write data shift in.
  ////////////////////////////////////////////////////////////////////////////////////////////

  shrp_phase_e               phase;
  shrp_phase_e               next_phase;
  shrp_op_e                  op;
  shrp_op_e                  next_op;
  logic [`SHRP_CNT_W-1:0]    cnt;
  logic [`SHRP_CNT_W-1:0]    next_cnt;
  logic [`SHRP_SHIFT_W-1:0]  shift;
  logic [`SHRP_SHIFT_W-1:0]  next_shift;
  logic                      rd_level;
  logic                      next_rd_level;
  logic                      wr_level;
  logic                      next_wr_level;
  logic [ADDR_W-1:0]         link_addr;
  logic [DATA_W-1:0]         link_data;

  // The instruction, address and data phases each count their own bits, then hand over to the next phase.
  always_comb
  begin
    next_phase    = phase;
    next_op       = op;
    next_cnt      = cnt + `SHRP_CNT_W'(1);
    next_shift    = {shift[`SHRP_SHIFT_W-2:0], serial_data_in_i};
    next_rd_level = rd_level;
    next_wr_level = wr_level;
    case (phase)
      SHRP_PH_INSTR:
      begin
        if (cnt == `SHRP_CNT_W'(`SHRP_INSTR_W - 1))
        begin
          next_phase = SHRP_PH_ADDR;
          next_cnt   = '0;
          // The first instruction bit received is its MSB.
          if (shift[`SHRP_OP_BIT] == `SHRP_OP_READ_VAL)
            next_op = SHRP_OP_READ;
          else
            next_op = SHRP_OP_WRITE;
        end
      end
      SHRP_PH_ADDR:
      begin
        if (cnt == `SHRP_CNT_W'(`SHRP_ADDR_W - 1))
        begin
          next_phase = SHRP_PH_DATA;
          next_cnt   = '0;
          // A read asks for the register as soon as the address is complete.
          if (op == SHRP_OP_READ)
            next_rd_level = 1'b1;
        end
      end
      SHRP_PH_DATA:
      begin
        // A read freezes the shifter so the captured address stays put.
        if (op == SHRP_OP_READ)
          next_shift = shift;
        if (cnt == `SHRP_CNT_W'(`SHRP_DATA_W - 1))
        begin
          next_phase = SHRP_PH_DONE;
          next_cnt   = '0;
          if (op == SHRP_OP_WRITE)
            next_wr_level = 1'b1;
        end
      end
      SHRP_PH_DONE:
      begin
        // Extra clocks before chip select rises are ignored.
        next_shift = shift;
        next_cnt   = cnt;
      end
      default:
      begin
        next_phase = SHRP_PH_INSTR;
        next_cnt   = '0;
      end
    endcase
  end

  // Chip select high clears the whole link side; the serial clock may be stopped then,
  // so the clear cannot wait for one of its edges.
  always_ff @(posedge serial_clock_i or posedge chip_select_n_i)
  begin
    if (chip_select_n_i)
    begin
      phase    <= SHRP_PH_INSTR;
      op       <= SHRP_OP_WRITE;
      cnt      <= '0;
      shift    <= '0;
      rd_level <= 1'b0;
      wr_level <= 1'b0;
    end
    else
    begin
      phase    <= next_phase;
      op       <= next_op;
      cnt      <= next_cnt;
      shift    <= next_shift;
      rd_level <= next_rd_level;
      wr_level <= next_wr_level;
    end
  end

  // A read froze with the address at the bottom; a write has the data byte below it.
  always_comb
  begin
    if (op == SHRP_OP_READ)
      link_addr = shift[ADDR_W-1:0];
    else
      link_addr = shift[`SHRP_SHIFT_W-1:DATA_W];
    link_data = shift[DATA_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Link domain, falling edge: read data shifts out.
  ////////////////////////////////////////////////////////////////////////////////////////////

  logic [DATA_W-1:0] out_shift;
  logic [DATA_W-1:0] next_out_shift;
  logic              next_oe;
  logic [DATA_W-1:0] read_word;

  // The first falling edge of a read data phase loads the word, later ones shift it left.
  always_comb
  begin
    next_out_shift = out_shift;
    next_oe        = serial_data_out_oe_o;
    if (serial_data_out_oe_o)
      next_out_shift = {out_shift[DATA_W-2:0], 1'b0};
    else if (phase == SHRP_PH_DATA && op == SHRP_OP_READ)
    begin
      next_out_shift = read_word;
      next_oe        = 1'b1;
    end
  end

  // The pin is released the moment chip select rises, not at a later clock edge.
  always_ff @(negedge serial_clock_i or posedge chip_select_n_i)
  begin
    if (chip_select_n_i)
    begin
      out_shift            <= '0;
      serial_data_out_oe_o <= 1'b0;
    end
    else
    begin
      out_shift            <= next_out_shift;
      serial_data_out_oe_o <= next_oe;
    end
  end

  // MSB of the shifter is the pin value; it is a flip-flop output.
  always_comb
  begin
    serial_data_out_o = out_shift[DATA_W-1];
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // System domain: request crossing and register access.
  ////////////////////////////////////////////////////////////////////////////////////////////

  logic [1:0]        req_sync;
  logic [1:0]        req_prev;
  logic [1:0]        next_req_prev;
  logic              wr_pulse;
  logic              rd_pulse;
  logic              next_write_strobe;
  logic              next_read_strobe;
  logic [ADDR_W-1:0] next_access_addr;

  // Request levels hold until chip select rises, so a level crossing is enough;
  // address and data behind them stand still for the whole time the level is high.
  shrp_sync #(
    .WIDTH (2)
  ) u_req_sync (
    .clk_i   (sys_clk_i),
    .rst_i   (rst_i),
    .async_i ({wr_level, rd_level}),
    .sync_o  (req_sync)
  );

  // Rising edges of the synchronised levels become one-cycle access pulses.
  always_comb
  begin
    next_req_prev     = req_sync;
    wr_pulse          = req_sync[1] & ~req_prev[1];
    rd_pulse          = req_sync[0] & ~req_prev[0];
    next_write_strobe = wr_pulse;
    next_read_strobe  = rd_pulse;
    next_access_addr  = access_addr_o;
    if (wr_pulse || rd_pulse)
      next_access_addr = link_addr;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      req_prev       <= '0;
      write_strobe_o <= 1'b0;
      read_strobe_o  <= 1'b0;
      access_addr_o  <= '0;
    end
    else
    begin
      req_prev       <= next_req_prev;
      write_strobe_o <= next_write_strobe;
      read_strobe_o  <= next_read_strobe;
      access_addr_o  <= next_access_addr;
    end
  end

  // The read word must be ready before the first falling edge after the address; at the
  // maximum serial rate that leaves a half period, about eight system clocks, for three.
  shrp_regfile #(
    .NUM_REGS (NUM_REGS),
    .ADDR_W   (ADDR_W),
    .DATA_W   (DATA_W)
  ) u_regfile (
    .clk_i   (sys_clk_i),
    .rst_i   (rst_i),
    .we_i    (wr_pulse),
    .waddr_i (link_addr),
    .wdata_i (link_data),
    .re_i    (rd_pulse),
    .raddr_i (link_addr),
    .rdata_o (read_word),
    .regs_o  (reg_values_o)
  );

endmodule

`default_nettype wire

/* test/shrp_monitor.sv */
// Assertion checker for shrp_top, bound to every instance at the foot of this file.
// Assumes the serial clock stands still while chip select is high.
`timescale 1ns/1ps
`default_nettype none
module shrp_monitor
#(
  parameter int NUM_REGS = 32,
  parameter int ADDR_W   = 11,
  parameter int DATA_W   = 8
)
(
  // Clocks, reset and link lines.
  input wire logic                       sys_clk_i,
  input wire logic                       rst_i,
  input wire logic                       serial_clock_i,
  input wire logic                       chip_select_n_i,
  input wire logic                       serial_data_in_i,
  input wire logic                       serial_data_out_o,
  input wire logic                       serial_data_out_oe_o,
  // Register side.
  input wire logic [NUM_REGS*DATA_W-1:0] reg_values_o,
  input wire logic                       write_strobe_o,
  input wire logic                       read_strobe_o,
  input wire logic [ADDR_W-1:0]          access_addr_o
);
  logic [4:0]        cnt;
  logic              op;
  logic [ADDR_W-1:0] ad;
  logic              exp_bit;
  // Edge count, operation and address of a frame; chip select high clears them as it does the link.
  always_ff @(posedge serial_clock_i or posedge chip_select_n_i)
  begin
    if (chip_select_n_i)
    begin
      cnt <= 5'h00;
      op  <= 1'b0;
      ad  <= '0;
    end
    else
    begin
      cnt <= (cnt == 5'h1f) ? cnt : cnt + 5'h01;
      op  <= (cnt == 5'h00) ? serial_data_in_i : op;
      ad  <= (cnt >= 5'h05 && cnt <= 5'h0f) ? {ad[ADDR_W-2:0], serial_data_in_i} : ad;
    end
  end
  // Expected read bit; zero past the byte and for an unmapped address, so stale data shows.
  always_comb
  begin
    exp_bit = 1'b0;
    if (cnt >= 5'h10 && cnt <= 5'h17 && int'(ad) < NUM_REGS)
      exp_bit = reg_values_o[int'(ad)*DATA_W+23-int'(cnt)];
  end
  ////////////////////////////////////////////////////////////////
  property p_oe_window;
    @(posedge serial_clock_i) disable iff (chip_select_n_i) serial_data_out_oe_o == (op && cnt >= 5'h10);
  endproperty
  a_oe_window: assert property (p_oe_window) else $error("enable outside read data");
  property p_read_bit;
    @(posedge serial_clock_i) disable iff (chip_select_n_i) (op && cnt >= 5'h10) |-> serial_data_out_o == exp_bit;
  endproperty
  a_read_bit: assert property (p_read_bit) else $error("wrong read bit");
  property p_oe_idle;
    @(posedge sys_clk_i) disable iff (rst_i) chip_select_n_i |-> !serial_data_out_oe_o && !serial_data_out_o;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("driving outside frame");
  property p_wr_pulse;
    @(posedge sys_clk_i) disable iff (rst_i) write_strobe_o |=> !write_strobe_o;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("long write strobe");
  property p_rd_pulse;
    @(posedge sys_clk_i) disable iff (rst_i) read_strobe_o |=> !read_strobe_o;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("long read strobe");
  property p_rd_addr;
    @(posedge sys_clk_i) disable iff (rst_i) read_strobe_o |-> !chip_select_n_i && access_addr_o == ad && op;
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read address");
  property p_wr_addr;
    @(posedge sys_clk_i) disable iff (rst_i) write_strobe_o |-> !chip_select_n_i && access_addr_o == ad && !op;
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write address");
  property p_reg_update;
    @(posedge sys_clk_i) disable iff (rst_i)
      $changed(reg_values_o) |-> ##[0:1] (write_strobe_o || $past(write_strobe_o));
  endproperty
  a_reg_update: assert property (p_reg_update) else $error("register moved without write");
  c_write: cover property (@(posedge sys_clk_i) write_strobe_o);
  c_read: cover property (@(posedge sys_clk_i) read_strobe_o);
  c_oe: cover property (@(posedge serial_clock_i) $rose(serial_data_out_oe_o));
endmodule
bind shrp_top shrp_monitor #(.NUM_REGS(NUM_REGS), .ADDR_W(ADDR_W), .DATA_W(DATA_W)) shrp_monitor_inst (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .serial_clock_i(serial_clock_i), .chip_select_n_i(chip_select_n_i),
  .serial_data_in_i(serial_data_in_i), .serial_data_out_o(serial_data_out_o),
  .serial_data_out_oe_o(serial_data_out_oe_o), .reg_values_o(reg_values_o), .write_strobe_o(write_strobe_o),
  .read_strobe_o(read_strobe_o), .access_addr_o(access_addr_o));
`default_nettype wire

/* test/shrp_host_model.sv */
// Host model: frames one register transfer on the serial link per call of xfer.
// Assumes the bench resolves the read data pin from the design's output enable.
`timescale 1ns/1ps
`default_nettype none
module shrp_host_model
#(
  parameter int HALF_NS = 260
)
(
  // Link lines from the host, and the resolved read data pin.
  output logic      serial_clock_o,
  output logic      chip_select_n_o,
  output logic      serial_data_in_o,
  input  wire logic serial_data_out_i
);
  // Idle link: clock low and still, chip select high. Chip select starts low and rises one
  // nanosecond later, so the link side sees a clean clearing edge even if its processes
  // are not yet waiting at time zero.
  initial
  begin
    serial_clock_o   = 1'b0;
    chip_select_n_o  = 1'b0;
    serial_data_in_o = 1'b0;
    #1;
    chip_select_n_o  = 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  // Instruction, address and data go out MSB first; fewer than 24 bits cuts the frame short.
  // The slow half period keeps clock high and low times legal and gives the device time to fetch.
  // It is no multiple of the system period, so the two clocks drift in phase against each other.
  task automatic xfer(input logic [4:0] instr, input logic [10:0] addr, input logic [7:0] wdata,
                      input int nbits, output logic [7:0] rdata);
    logic [23:0] word;
    word            = {instr, addr, wdata};
    rdata           = 8'h00;
    chip_select_n_o = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      serial_data_in_o = word[23-i];
      #(HALF_NS);
      serial_clock_o = 1'b1;
      if (i >= 16) rdata = {rdata[6:0], serial_data_out_i};
      #(HALF_NS);
      serial_clock_o = 1'b0;
    end
    #(HALF_NS);
    chip_select_n_o  = 1'b1;
    serial_data_in_o = ~serial_data_in_o; // Released line flips so nothing leans on the last bit.
    #(HALF_NS);
  endtask
endmodule
`default_nettype wire

/* test/tb_serial_host_register_port.sv */
// Self-checking bench for shrp_top with a host model driving the serial link.
// Assumes the package, design, checker and host model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_host_register_port;
  localparam int NR = 8; // Small bank, so address 8 is the first unmapped one.
  logic            sys_clk = 1'b0;
  logic            rst = 1'b1;
  logic            sclk, cs_n, serial_data_in, serial_data_out, oe, ws, rs;
  logic [NR*8-1:0] regs;
  logic [10:0]     acc;
  logic [7:0]      exp_reg [NR];
  logic [7:0]      rd;
  wire             sdo_pin;
  int              fail_count = 0;
  int              n_checks = 0;
  int              cycles = 0;
  int              wcnt = 0;
  int              rcnt = 0;
  // System clock of 25 ns; the pin floats whenever the design's enable is low.
  always #12.5 sys_clk = ~sys_clk;
  assign sdo_pin = oe ? serial_data_out : 1'bz;
  shrp_top #(.NUM_REGS(NR)) shrp_top_inst (.sys_clk_i(sys_clk), .rst_i(rst), .serial_clock_i(sclk),
    .chip_select_n_i(cs_n), .serial_data_in_i(serial_data_in), .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(oe),
    .reg_values_o(regs), .write_strobe_o(ws), .read_strobe_o(rs), .access_addr_o(acc));
  shrp_host_model shrp_host_model_inst (.serial_clock_o(sclk), .chip_select_n_o(cs_n),
    .serial_data_in_o(serial_data_in), .serial_data_out_i(sdo_pin));
  // Strobe counters and hang limit; fifteen frames of some 520 cycles fit well below it.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (ws === 1'b1) wcnt++;
    if (rs === 1'b1) rcnt++;
    if (cycles == 12000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s: %h vs %h", $time, what, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [NR*8-1:0] exp_flat();
    logic [NR*8-1:0] v;
    for (int k = 0; k < NR; k++) v[k*8+:8] = exp_reg[k];
    return v;
  endfunction
  // One write frame; only a whole frame to a mapped address may move a register.
  task automatic do_write(input logic [10:0] a, input logic [7:0] d, input int nbits);
    int w0;
    w0 = wcnt;
    shrp_host_model_inst.xfer(5'h0b, a, d, nbits, rd);
    repeat (2) @(posedge sys_clk);
    #1; // Look at settled outputs; the next frame then also starts off the edge.
    if (nbits == 24 && a < NR)
    begin
      exp_reg[a] = d;
      check(wcnt, w0 + 1, "write strobe");
      check(acc, a, "write address");
    end
    else if (nbits < 24)
      check(wcnt, w0, "cut write strobe");
    check(regs, exp_flat(), "registers");
  endtask
  // One read frame; an unmapped address reads as zero and the pin floats afterwards.
  task automatic do_read(input logic [4:0] instr, input logic [10:0] a);
    int r0;
    r0 = rcnt;
    shrp_host_model_inst.xfer(instr, a, 8'h00, 24, rd);
    repeat (2) @(posedge sys_clk);
    #1; // Look at settled outputs; the next frame then also starts off the edge.
    check(rd, (a < NR) ? exp_reg[a] : 8'h00, "read data");
    if (a < NR)
    begin
      check(rcnt, r0 + 1, "read strobe");
      check(acc, a, "read address");
    end
    check({oe, serial_data_out}, 2'b00, "idle pin");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    foreach (exp_reg[k]) exp_reg[k] = 8'h00;
    check(regs, exp_flat(), "reset registers");
    check({ws, rs, oe, serial_data_out}, 4'h0, "reset outputs");
  endtask
  // Both ends of the bank and both instruction low-bit patterns, reads back to back.
  task automatic t_write_read();
    logic [10:0] al [3] = '{11'h000, 11'h007, 11'h003};
    logic [7:0]  dl [3] = '{8'h5a, 8'ha5, 8'hff};
    for (int k = 0; k < 3; k++) do_write(al[k], dl[k], 24);
    for (int k = 0; k < 3; k++) do_read((k == 0) ? 5'h10 : 5'h1f, al[k]);
  endtask
  // First unmapped address, the top address, and a high address bit that must not alias.
  task automatic t_unmapped();
    do_write(11'h008, 8'h3c, 24);
    do_write(11'h7ff, 8'hc3, 24);
    do_write(11'h403, 8'h11, 24);
    do_read(5'h10, 11'h008);
    do_read(5'h1f, 11'h403);
  endtask
  // Frames cut short, one bit short at the worst, leave the register alone.
  task automatic t_cut();
    do_write(11'h002, 8'h77, 20);
    do_write(11'h002, 8'h77, 23);
    do_write(11'h002, 8'h66, 24);
    do_read(5'h1f, 11'h002);
  endtask
  // Reset held for 12 cycles, released just after an edge.
  initial
  begin
    repeat (12) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_write_read();
    t_unmapped();
    t_cut();
    tally_and_finish();
  end
endmodule
`default_nettype wire
